// ### spipg_consts.vh
// Purpose: constants for the serial programming command interpreter
// Assumes: 100 MHz core clock
// Notes: opcode bytes and wait times of the programming instructions
`ifndef SPIPG_CONSTS_VH
`define SPIPG_CONSTS_VH
`define SPIPG_OP_ENABLE 8'hAC
`define SPIPG_EN_KEY 8'h53
`define SPIPG_OP_RD_PROG 4'h2
`define SPIPG_OP_LD_PAGE 4'h4
`define SPIPG_OP_WR_PAGE 8'h4C
`define SPIPG_OP_RD_EE 8'hA0
`define SPIPG_OP_WR_EE 8'hC0
`define SPIPG_OP_RD_LOCK 8'h58
`define SPIPG_OP_RD_FUSE 8'h50
`define SPIPG_SUB_ERASE 3'h4
`define SPIPG_SUB_LOCK 3'h7
`define SPIPG_SUB_FUSE_LO 8'hA0
`define SPIPG_SUB_FUSE_HI 8'hA8
`define SPIPG_SUB_RD_FHI 8'h08
`define SPIPG_T_FLASH_US 4500
`define SPIPG_T_EEPROM_US 9000
`define SPIPG_CLK_MHZ 100
`define SPIPG_LOCK_RST 6'h3F
`define SPIPG_FUSE_LO_RST 8'hFF
`define SPIPG_FUSE_HI_RST 8'hFF
`endif

// ### spipg_top.v
// Purpose: decodes four-byte serial programming instructions and runs the memories
// Assumes: sck/mosi/prog_reset_n come from the programmer, asynchronous to core_clk_i
// Notes: memories are flip-flop arrays; writes are modelled as busy intervals
`timescale 1ns/100ps
`include "spipg_consts.vh"

// Functional notes
// R1: enable instruction AC 53 xx xx enters programming mode while reset is low.
// R2: AC with byte two 100x xxxx erases EEPROM and flash.
// R3: read program memory returns low or high byte of 13-bit word address.
// R4: page load stores byte four at word b[5:0]; low before high.
// R5: 4C commits buffered page to flash at page address a:b[7:6].
// R6: A0 returns, in byte four, the EEPROM byte at the 9-bit address in bytes two and three.
// R7: C0 writes byte four to EEPROM at 9-bit address.
// R8: 58 00 returns six lock bits; zero means programmed.
// R9: AC 111x writes lock bits from byte four low six bits.
// R10: AC A0 writes low fuse, AC A8 writes high fuse.
// R11: 50 00 reads low fuse, 58 08 reads high fuse.
// R12: programmer enables programming before any program or erase instruction.
// R13: reads inside a page being written return all ones until done.
// R14: programmer waits 4.5 ms after page write, 9.0 ms after EEPROM or erase.
// R15: an EEPROM location is erased automatically before being written.
// R16: four bytes msb first; results drive MISO during the fourth byte.
// R17: unknown instructions change nothing.
module spipg_top #(
	parameter FLASH_WORDS = 8192,
	parameter EE_BYTES = 512,
	parameter T_FLASH_CYC = `SPIPG_T_FLASH_US * `SPIPG_CLK_MHZ,
	parameter T_EE_CYC = `SPIPG_T_EEPROM_US * `SPIPG_CLK_MHZ
) (
	input wire core_clk_i,
	input wire reset_n_i,
	input wire prog_reset_n_i,
	input wire sck_i,
	input wire mosi_i,
	output wire miso_o,
	output wire miso_oe_o,
	output wire prog_mode_o,
	output wire busy_o,
	output wire cmd_valid_o,
	input wire cmd_ready_i,
	output wire [31:0] cmd_data_o
);
	reg [2:0] sck_s_q;
	reg [1:0] mosi_s_q;
	reg [1:0] rst_s_q;
	always @(posedge core_clk_i) begin
		sck_s_q <= {sck_s_q[1:0], sck_i};
		mosi_s_q <= {mosi_s_q[0], mosi_i};
		rst_s_q <= {rst_s_q[0], prog_reset_n_i};
	end
	wire sck_rise = sck_s_q[1] & ~sck_s_q[2];
	wire sck_fall = ~sck_s_q[1] & sck_s_q[2];
	wire in_reset = ~rst_s_q[1];

	reg [31:0] shift_q;
	reg [4:0] bit_q;
	reg [7:0] miso_q;
	reg [7:0] out_q;
	reg prog_en_q;
	reg [7:0] flash_lo_q [0:FLASH_WORDS-1];
	reg [7:0] flash_hi_q [0:FLASH_WORDS-1];
	reg [7:0] page_lo_q [0:63];
	reg [7:0] page_hi_q [0:63];
	reg [7:0] ee_q [0:EE_BYTES-1];
	reg [5:0] lock_q;
	reg [7:0] fuse_lo_q;
	reg [7:0] fuse_hi_q;
	reg [31:0] busy_cnt_q;
	reg [6:0] busy_page_q;
	reg busy_flash_q;
	reg [8:0] busy_ee_q;
	reg busy_eew_q;

	// two-entry buffer of complete instructions
	reg [31:0] buf_q [0:1];
	reg [1:0] cnt_q;
	reg wp_q;
	reg rp_q;
	wire buf_in_ready = (cnt_q != 2'h2);
	wire buf_out_valid = (cnt_q != 2'h0);
	wire [31:0] cmd = buf_q[rp_q];
	wire word_done = sck_rise & (bit_q == 5'h1F) & in_reset;
	wire push = word_done & buf_in_ready;
	// a stalled consumer holds the head; no enable, erase or write executes until it is taken; reads answer from the shift path at once
	wire pop = buf_out_valid & ~busy_o & cmd_ready_i;
	assign cmd_valid_o = buf_out_valid;
	assign cmd_data_o = cmd;

	always @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			cnt_q <= 2'h0;
			wp_q <= 1'b0;
			rp_q <= 1'b0;
		end else begin
			if (push) begin
				buf_q[wp_q] <= {shift_q[30:0], mosi_s_q[1]};
				wp_q <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// at the 24th rise the last bit of byte three is still in the synchroniser
	wire [23:0] hdr = {shift_q[22:0], mosi_s_q[1]};
	wire [7:0] b1 = hdr[23:16];
	wire [7:0] b2 = hdr[15:8];
	wire [7:0] b3 = hdr[7:0];
	wire [12:0] rd_word = {b2[4:0], b3};
	wire [8:0] rd_ee = {b2[0], b3};

	// read data for the byte about to start: depends on the first three bytes
	function [7:0] rd_sel;
		input dummy;
		begin
			rd_sel = 8'h00;
			if (b1[7:4] == `SPIPG_OP_RD_PROG && b1[2:0] == 3'h0) begin //R3
				if (busy_flash_q && rd_word[12:6] == busy_page_q)
					rd_sel = 8'hFF; //R13
				else
					rd_sel = b1[3] ? flash_hi_q[rd_word] : flash_lo_q[rd_word];
			end else if (b1 == `SPIPG_OP_RD_EE) begin //R6
				rd_sel = (busy_eew_q && busy_ee_q == rd_ee) ? 8'hFF : ee_q[rd_ee];
			end else if (b1 == `SPIPG_OP_RD_LOCK && b2 == 8'h00) begin
				rd_sel = {2'h3, lock_q}; //R8
			end else if (b1 == `SPIPG_OP_RD_FUSE && b2 == 8'h00) begin
				rd_sel = fuse_lo_q; //R11
			end else if (b1 == `SPIPG_OP_RD_LOCK && b2 == `SPIPG_SUB_RD_FHI) begin
				rd_sel = fuse_hi_q; //R11
			end
		end
	endfunction

	always @(posedge core_clk_i) begin
		if (!reset_n_i || in_reset == 1'b0) begin
			bit_q <= 5'h00;
			shift_q <= 32'h0000_0000;
			out_q <= 8'h00;
			miso_q <= 8'h00;
		end else begin
			if (sck_rise) begin //R16
				shift_q <= {shift_q[30:0], mosi_s_q[1]};
				bit_q <= bit_q + 5'h01;
				if (bit_q == 5'h17)
					out_q <= rd_sel(1'b0);
			end
			if (sck_fall) begin
				if (bit_q == 5'h18)
					miso_q <= out_q;
				else
					miso_q <= {miso_q[6:0], 1'b0};
			end
		end
	end
	assign miso_o = miso_q[7]; //R16
	assign miso_oe_o = prog_en_q;
	assign prog_mode_o = prog_en_q;

	wire [7:0] c1 = cmd[31:24];
	wire [7:0] c2 = cmd[23:16];
	wire [7:0] c3 = cmd[15:8];
	wire [7:0] c4 = cmd[7:0];
	wire [6:0] wr_page = {c2[4:0], c3[7:6]};
	wire [8:0] wr_ee = {c2[0], c3};
	assign busy_o = (busy_cnt_q != 32'h0000_0000);
	integer i;

	always @(posedge core_clk_i) begin
		if (!reset_n_i || !in_reset) begin
			prog_en_q <= 1'b0;
			busy_cnt_q <= 32'h0000_0000;
			busy_flash_q <= 1'b0;
			busy_eew_q <= 1'b0;
			busy_page_q <= 7'h00;
			busy_ee_q <= 9'h000;
			if (!reset_n_i) begin
				lock_q <= `SPIPG_LOCK_RST;
				fuse_lo_q <= `SPIPG_FUSE_LO_RST;
				fuse_hi_q <= `SPIPG_FUSE_HI_RST;
			end
		end else begin
			if (busy_o)
				busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
			else begin
				busy_flash_q <= 1'b0;
				busy_eew_q <= 1'b0;
			end
			if (pop) begin
				if (c1 == `SPIPG_OP_ENABLE && c2 == `SPIPG_EN_KEY) begin
					prog_en_q <= 1'b1; //R1
				end else if (prog_en_q) begin //R12
					if (c1 == `SPIPG_OP_ENABLE && c2[7:5] == `SPIPG_SUB_ERASE) begin
						for (i = 0; i < FLASH_WORDS; i = i + 1) begin //R2
							flash_lo_q[i] <= 8'hFF;
							flash_hi_q[i] <= 8'hFF;
						end
						for (i = 0; i < EE_BYTES; i = i + 1)
							ee_q[i] <= 8'hFF;
						lock_q <= `SPIPG_LOCK_RST;
						busy_cnt_q <= T_EE_CYC;
					end else if (c1 == `SPIPG_OP_ENABLE && c2[7:5] == `SPIPG_SUB_LOCK) begin
						lock_q <= lock_q & c4[5:0]; //R9
					end else if (c1 == `SPIPG_OP_ENABLE && c2 == `SPIPG_SUB_FUSE_LO) begin
						fuse_lo_q <= c4; //R10
					end else if (c1 == `SPIPG_OP_ENABLE && c2 == `SPIPG_SUB_FUSE_HI) begin
						fuse_hi_q <= c4; //R10
					end else if (c1[7:4] == `SPIPG_OP_LD_PAGE && c1[2:0] == 3'h0) begin
						if (c1[3]) //R4
							page_hi_q[c3[5:0]] <= c4;
						else
							page_lo_q[c3[5:0]] <= c4;
					end else if (c1 == `SPIPG_OP_WR_PAGE) begin
						for (i = 0; i < 64; i = i + 1) begin //R5
							flash_lo_q[{wr_page, i[5:0]}] <= page_lo_q[i];
							flash_hi_q[{wr_page, i[5:0]}] <= page_hi_q[i];
						end
						busy_flash_q <= 1'b1; //R13
						busy_page_q <= wr_page;
						busy_cnt_q <= T_FLASH_CYC;
					end else if (c1 == `SPIPG_OP_WR_EE) begin
						ee_q[wr_ee] <= c4; //R7 R15
						busy_eew_q <= 1'b1;
						busy_ee_q <= wr_ee;
						busy_cnt_q <= T_EE_CYC;
					end //R17
				end
			end
		end
	end
endmodule // spipg_top

// ### spipg_top_asserts.sv
// Purpose: port checks of spipg_top
// Assumes: one core clock domain
// Notes: bound to every spipg_top
`timescale 1ns/100ps
module spipg_top_asserts (
	input wire core_clk_i,
	input wire reset_n_i,
	input wire prog_reset_n_i,
	input wire miso_oe_o,
	input wire prog_mode_o,
	input wire busy_o,
	input wire cmd_valid_o,
	input wire cmd_ready_i,
	input wire [31:0] cmd_data_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_pin_high;
		prog_reset_n_i [*5];
	endsequence
	sequence s_busy_rise;
		$rose(busy_o);
	endsequence
	a_mode_pin_clear: assert property (s_pin_high |=> !prog_mode_o)
		else $error("mode kept with pin high");
	a_mode_rise_pin: assert property ($rose(prog_mode_o) |-> !prog_reset_n_i)
		else $error("mode entered with pin high");
	a_oe_needs_mode: assert property (!prog_mode_o [*2] |-> !miso_oe_o)
		else $error("miso driven outside mode");
	a_busy_needs_mode: assert property (s_busy_rise |-> prog_mode_o)
		else $error("write before enable");
	a_busy_holds: assert property (s_busy_rise |-> busy_o [*8])
		else $error("write interval too short");
	a_busy_ends: assert property (s_busy_rise |-> ##[1:1000] !busy_o)
		else $error("write interval never ends");
	a_head_waits: assert property (cmd_valid_o && busy_o && !prog_reset_n_i |=>
		cmd_valid_o && $stable(cmd_data_o)) else $error("head left while busy");
	a_reset_quiet: assert property ($rose(reset_n_i) |-> !prog_mode_o && !busy_o)
		else $error("outputs set after reset");
	a_head_stalls: assert property (cmd_valid_o && !cmd_ready_i |=>
		cmd_valid_o && $stable(cmd_data_o)) else $error("head left while stalled");
endmodule // spipg_top_asserts
bind spipg_top spipg_top_asserts i_asserts (.core_clk_i, .reset_n_i, .prog_reset_n_i,
	.miso_oe_o, .prog_mode_o, .busy_o, .cmd_valid_o, .cmd_ready_i, .cmd_data_o);

// ### spipg_prog_model.sv
// Purpose: programmer side, SPI master
// Assumes: 125 ns sck period
// Notes: sck idles low between frames
`timescale 1ns/100ps
module spipg_prog_model (
	output logic sck_o,
	output logic mosi_o,
	input wire logic miso_i
);
	initial sck_o = 1'b0;
	initial mosi_o = 1'b0;
	task automatic frame(input logic [31:0] c, output logic [7:0] r);
		for (int i = 31; i >= 0; i--) begin
			mosi_o = c[i];
			#62.5 sck_o = 1'b1;
			if (i < 8) r[i] = miso_i;
			#62.5 sck_o = 1'b0;
		end
		mosi_o = ~c[0];
		#250;
	endtask
endmodule // spipg_prog_model

// ### spipg_top_tb.sv
// Purpose: self-checking bench of spipg_top
// Assumes: short write intervals
// Notes: seed fixed
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module spipg_top_tb;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic prog_reset_n_i = 1'b0;
	wire sck, mosi, miso, busy, pmode, cvalid, moe;
	wire [31:0] cdata;
	logic cmd_ready = 1'b1;
	int mismatches = 0;
	int n_tests = 0;
	logic [7:0] r, d, d2;
	logic [12:0] wa;
	logic [8:0] ea;
	spipg_top #(.T_FLASH_CYC(600), .T_EE_CYC(800)) i_dut (.core_clk_i, .reset_n_i,
		.prog_reset_n_i, .sck_i(sck), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(moe),
		.prog_mode_o(pmode), .busy_o(busy), .cmd_valid_o(cvalid), .cmd_ready_i(cmd_ready),
		.cmd_data_o(cdata));
	spipg_prog_model i_prog (.sck_o(sck), .mosi_o(mosi), .miso_i(miso));
	initial forever #5 core_clk_i = ~core_clk_i;
	function automatic logic [31:0] prd(logic [12:0] a, logic h);
		return {4'h2, h, 6'h00, a, 8'h00};
	endfunction
	task automatic send(input logic [31:0] c);
		i_prog.frame(c, r);
	endtask
	task automatic idle();
		repeat (20) @(negedge core_clk_i);
		for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge core_clk_i);
		`CHK(busy, 1'b0)
	endtask
	task automatic finish_test();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#600000 mismatches++;
		finish_test();
	end
	initial begin
		r = $urandom(11871);
		repeat (20) @(negedge core_clk_i);
		reset_n_i = 1'b1;
		send(32'hAC80_0000);
		`CHK(busy, 1'b0)
		idle();
		send(32'hAC53_0000);
		idle();
		`CHK(pmode, 1'b1)
		`CHK(moe, 1'b1)
		send(32'h5808_0000);
		`CHK(r, 8'hFF)
		d = $urandom;
		send({24'hACA000, d});
		idle();
		send(32'h5000_0000);
		`CHK(r, d)
		d = $urandom;
		cmd_ready = 1'b0;
		send({24'hACA800, d});
		`CHK(cvalid, 1'b1)
		`CHK(cdata, {24'hACA800, d})
		send(32'h5808_0000);
		`CHK(r, 8'hFF)
		cmd_ready = 1'b1;
		send(32'hAC00_0000);
		send(32'hF012_3456);
		idle();
		send(32'h5808_0000);
		`CHK(r, d)
		d = $urandom;
		send({24'hACE000, d});
		idle();
		send(32'h5800_0000);
		`CHK(r[5:0], 6'h3F & d[5:0])
		for (int i = 0; i < 2; i++) begin
			ea = i ? 9'($urandom) : 9'h1FF;
			d = $urandom;
			send({8'hC0, 7'h00, ea, d});
			send({8'hA0, 7'h00, ea, 8'h00});
			`CHK(cvalid, 1'b1)
			`CHK(r, 8'hFF)
			idle();
			send({8'hC0, 7'h00, ea, ~d});
			idle();
			send({8'hA0, 7'h00, ea, 8'h00});
			`CHK(r, ~d)
			wa = i ? 13'($urandom) : 13'h1FFF;
			d2 = $urandom;
			send({8'h40, 10'h000, wa[5:0], d});
			send({8'h48, 10'h000, wa[5:0], d2});
			send({8'h4C, 3'h0, wa[12:8], wa[7:6], 14'h0});
			send(prd(wa, 1'b0));
			`CHK(r, 8'hFF)
			idle();
			send(prd(wa, 1'b0));
			`CHK(r, d)
			send(prd(wa, 1'b1));
			`CHK(r, d2)
		end
		send(32'hAC80_0000);
		idle();
		send(prd(wa, 1'b1));
		`CHK(r, 8'hFF)
		send({8'hA0, 7'h00, ea, 8'h00});
		`CHK(r, 8'hFF)
		prog_reset_n_i = 1'b1;
		idle();
		`CHK(pmode, 1'b0)
		`CHK(moe, 1'b0)
		finish_test();
	end
endmodule // spipg_top_tb
